// File: inc/adc_ctl_pkg.sv
// constants and types for the sar converter control sequencer
// assumes a single 200 MHz system clock domain and an 8-bit sfr bus
package adc_ctl_pkg;

  localparam logic [7:0] SFR_ADDR_CTL = 8'hE8;
  localparam logic [7:0] CTL_RESET    = 8'h00;

  localparam int BIT_POWER     = 7;
  localparam int BIT_TRACK_SEL = 6;
  localparam int BIT_DONE      = 5;
  localparam int BIT_BUSY      = 4;
  localparam int BIT_SRC_HI    = 3;
  localparam int BIT_SRC_LO    = 2;
  localparam int BIT_WINDOW    = 1;
  localparam int BIT_ALIGN     = 0;

  localparam int RESULT_W = 10;

  // tracking window length in converter clock periods
  localparam logic [1:0] TRACK_SAR_CLKS = 2'h3;

  typedef enum logic [1:0] {
    SRC_SW_WRITE = 2'b00,
    SRC_TIMER3   = 2'b01,
    SRC_EXT_PIN  = 2'b10,
    SRC_TIMER2   = 2'b11
  } start_src_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONV  = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic power;
    logic track;
    logic start;
  } core_ctl_t;

endpackage : adc_ctl_pkg

// File: hdl/sar_adc_control_sequencer.sv
// control and status sequencer for a successive-approximation converter
// assumes the sfr bus, timer strobes, start pin and core status are all
// synchronous to clk_sys; sar_tick marks one converter clock period
//
// Overview of operation
// - enable bit set powers the converter and lets it accept starts
// - enable bit clear keeps it shut down, no tracking or conversion
// - track select zero: track always except while converting
// - track select one: tracking follows the start source field
// - source 00: software busy write opens a three sar clock window
// - source 01: timer 3 overflow opens a three sar clock window
// - source 10: track only while the external start pin is low
// - source 11: timer 2 overflow opens a three sar clock window
// - done flag sets on each finished conversion, only software clears
// - busy reads one through the tracking window and the conversion, zero otherwise and after reset
// - busy falling edge raises an interrupt when it is enabled
// - busy write one starts only with source 00, writing zero does nothing
// - source 00: a software busy write of one made while idle and powered starts a conversion
// - source 01: a timer 3 overflow while idle and powered starts a conversion
// - source 10: a rising start pin edge while idle and powered starts a conversion
// - source 11: a timer 2 overflow while idle and powered starts a conversion
// - window flag sets on a matching result, stays until software clears
// - align bit zero: result right justified over high and low bytes
`timescale 1ns/1ps
`default_nettype none

module sar_adc_control_sequencer (
  input  wire  logic                  clk_sys,
  input  wire  logic                  sys_rst,
  input  wire  logic [7:0]            sfr_addr,
  input  wire  logic                  sfr_wr,
  input  wire  logic [7:0]            sfr_wdata,
  output logic [7:0]                  sfr_rdata,
  input  wire  logic                  sar_tick,
  input  wire  logic                  timer2_ovf,
  input  wire  logic                  timer3_ovf,
  input  wire  logic                  ext_start_pin,
  input  wire  logic                  core_done,
  input  wire  logic [9:0]            core_result,
  input  wire  logic                  window_match,
  input  wire  logic                  irq_enable,
  output adc_ctl_pkg::core_ctl_t      core_ctl,
  output logic [7:0]                  result_high_byte,
  output logic [7:0]                  result_low_byte,
  output logic                        conv_irq
);

  logic                     conv_power_on_q;
  logic                     track_select_q;
  logic [1:0]               start_source_sel_q;
  logic                     conv_done_flag_q;
  logic                     window_hit_flag_q;
  logic                     result_align_left_q;
  adc_ctl_pkg::seq_state_t  state_q;
  adc_ctl_pkg::seq_state_t  state_d;
  logic [1:0]               tick_cnt_q;
  logic [1:0]               tick_cnt_d;
  logic                     pin_prev_q;
  logic                     busy_q;
  logic [7:0]               sfr_rdata_q;
  adc_ctl_pkg::core_ctl_t   core_ctl_q;
  logic [7:0]               res_hi_q;
  logic [7:0]               res_lo_q;
  logic                     conv_irq_q;

  // decode
  wire ctl_wr     = sfr_wr && (sfr_addr == adc_ctl_pkg::SFR_ADDR_CTL);
  wire busy_wr1   = ctl_wr && sfr_wdata[adc_ctl_pkg::BIT_BUSY];
  wire src_sw     = (start_source_sel_q == adc_ctl_pkg::SRC_SW_WRITE);
  wire src_t3     = (start_source_sel_q == adc_ctl_pkg::SRC_TIMER3);
  wire src_pin    = (start_source_sel_q == adc_ctl_pkg::SRC_EXT_PIN);
  wire src_t2     = (start_source_sel_q == adc_ctl_pkg::SRC_TIMER2);
  wire pin_rise   = ext_start_pin && !pin_prev_q;

  // start request from the selected source; a write of zero never starts
  wire start_req  = (src_sw && busy_wr1)
                  || (src_t3 && timer3_ovf)
                  || (src_pin && pin_rise)
                  || (src_t2 && timer2_ovf);

  // starts are ignored while busy or powered down
  wire start_ok   = conv_power_on_q && (state_q == adc_ctl_pkg::ST_IDLE) && start_req;
  // pin mode samples at the edge, so no fixed window precedes the conversion
  wire use_window = track_select_q && !src_pin;
  wire win_end    = (state_q == adc_ctl_pkg::ST_TRACK) && sar_tick
                  && (tick_cnt_q == adc_ctl_pkg::TRACK_SAR_CLKS - 2'h1);

  always_comb begin
    state_d    = state_q;
    tick_cnt_d = tick_cnt_q;
    unique case (state_q)
      adc_ctl_pkg::ST_IDLE: begin
        tick_cnt_d = 2'h0;
        if (start_ok) begin
          state_d = use_window ? adc_ctl_pkg::ST_TRACK : adc_ctl_pkg::ST_CONV;
        end
      end
      adc_ctl_pkg::ST_TRACK: begin
        if (sar_tick) begin
          tick_cnt_d = tick_cnt_q + 2'h1;
        end
        if (win_end) begin
          state_d = adc_ctl_pkg::ST_CONV;
        end
      end
      adc_ctl_pkg::ST_CONV: begin
        if (core_done) begin
          state_d = adc_ctl_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = adc_ctl_pkg::ST_IDLE;
      end
    endcase
    if (!conv_power_on_q) begin
      state_d    = adc_ctl_pkg::ST_IDLE;
      tick_cnt_d = 2'h0;
    end
  end

  wire busy_d = (state_d != adc_ctl_pkg::ST_IDLE);

  // tracking level toward the analog core
  wire track_d = conv_power_on_q && (state_d != adc_ctl_pkg::ST_CONV)
               && (!track_select_q
                   || (src_pin && !ext_start_pin)
                   || (state_d == adc_ctl_pkg::ST_TRACK));

  wire conv_start_d = (state_d == adc_ctl_pkg::ST_CONV) && (state_q != adc_ctl_pkg::ST_CONV);

  // a finishing conversion beats a software clear in the same cycle
  wire done_evt = core_done && (state_q == adc_ctl_pkg::ST_CONV);
  wire done_d   = done_evt
                || (conv_done_flag_q && !(ctl_wr && !sfr_wdata[adc_ctl_pkg::BIT_DONE]));
  wire win_d    = (done_evt && window_match)
                || (window_hit_flag_q && !(ctl_wr && !sfr_wdata[adc_ctl_pkg::BIT_WINDOW]));

  wire [7:0] hi_right = {6'h00, core_result[9:8]};
  wire [7:0] lo_right = core_result[7:0];
  wire [7:0] hi_left  = core_result[9:2];
  wire [7:0] lo_left  = {core_result[1:0], 6'h00};

  wire [7:0] ctl_view = {conv_power_on_q, track_select_q, conv_done_flag_q, busy_q,
                         start_source_sel_q, window_hit_flag_q, result_align_left_q};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      conv_power_on_q     <= adc_ctl_pkg::CTL_RESET[adc_ctl_pkg::BIT_POWER];
      track_select_q      <= adc_ctl_pkg::CTL_RESET[adc_ctl_pkg::BIT_TRACK_SEL];
      start_source_sel_q  <= adc_ctl_pkg::CTL_RESET[adc_ctl_pkg::BIT_SRC_HI:adc_ctl_pkg::BIT_SRC_LO];
      result_align_left_q <= adc_ctl_pkg::CTL_RESET[adc_ctl_pkg::BIT_ALIGN];
    end else if (ctl_wr) begin
      conv_power_on_q     <= sfr_wdata[adc_ctl_pkg::BIT_POWER];
      track_select_q      <= sfr_wdata[adc_ctl_pkg::BIT_TRACK_SEL];
      start_source_sel_q  <= sfr_wdata[adc_ctl_pkg::BIT_SRC_HI:adc_ctl_pkg::BIT_SRC_LO];
      result_align_left_q <= sfr_wdata[adc_ctl_pkg::BIT_ALIGN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q           <= adc_ctl_pkg::ST_IDLE;
      tick_cnt_q        <= 2'h0;
      busy_q            <= 1'b0;
      pin_prev_q        <= 1'b0;
      conv_done_flag_q  <= 1'b0;
      window_hit_flag_q <= 1'b0;
    end else begin
      state_q           <= state_d;
      tick_cnt_q        <= tick_cnt_d;
      busy_q            <= busy_d;
      pin_prev_q        <= ext_start_pin;
      conv_done_flag_q  <= done_d;
      window_hit_flag_q <= win_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      core_ctl_q  <= '0;
      conv_irq_q  <= 1'b0;
      sfr_rdata_q <= adc_ctl_pkg::CTL_RESET;
    end else begin
      core_ctl_q  <= '{power: conv_power_on_q, track: track_d, start: conv_start_d};
      conv_irq_q  <= busy_q && !busy_d && irq_enable;
      sfr_rdata_q <= ctl_view;
    end
  end

  // the result bytes keep the alignment in force when the conversion ended
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
    end else if (done_evt) begin
      res_hi_q <= result_align_left_q ? hi_left : hi_right;
      res_lo_q <= result_align_left_q ? lo_left : lo_right;
    end
  end

  assign sfr_rdata        = sfr_rdata_q;
  assign core_ctl         = core_ctl_q;
  assign result_high_byte = res_hi_q;
  assign result_low_byte  = res_lo_q;
  assign conv_irq         = conv_irq_q;

  sequence s_sw_start;
    conv_power_on_q && state_q == adc_ctl_pkg::ST_IDLE && src_sw && busy_wr1;
  endsequence

  sequence s_window_open;
    state_q == adc_ctl_pkg::ST_TRACK;
  endsequence

  AST_OFF_NO_ACTIVITY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !conv_power_on_q |=> state_q == adc_ctl_pkg::ST_IDLE && !core_ctl_q.track)
    else $error("converter active while powered down");

  AST_CONT_TRACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_power_on_q && !track_select_q && state_d != adc_ctl_pkg::ST_CONV |=> core_ctl_q.track)
    else $error("continuous tracking dropped while idle");

  AST_SW_WINDOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_sw_start and track_select_q |=> s_window_open ##0 core_ctl_q.track)
    else $error("software write did not open a tracking window");

  AST_WINDOW_LEN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    win_end |=> state_q == adc_ctl_pkg::ST_CONV && core_ctl_q.start ##1 !core_ctl_q.start)
    else $error("conversion did not follow the end of the tracking window");

  AST_WINDOW_TICKS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_window_open and (conv_power_on_q && tick_cnt_q != 2'h2) |=> s_window_open)
    else $error("tracking window closed before three converter clocks");

  AST_PIN_TRACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_power_on_q && track_select_q && src_pin && ext_start_pin |=> !core_ctl_q.track)
    else $error("tracking while start pin high");

  AST_DONE_STICKY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_done_flag_q && !ctl_wr |=> conv_done_flag_q)
    else $error("done flag cleared by hardware");

  AST_DONE_SET: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done_evt |=> conv_done_flag_q && !busy_q)
    else $error("finished conversion left done flag clear or busy set");

  AST_IRQ_FALL: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(busy_q) && $past(irq_enable) |-> conv_irq_q)
    else $error("busy fall without interrupt");

  AST_WRITE0_NOSTART: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_q == adc_ctl_pkg::ST_IDLE && src_sw && !busy_wr1 |=> state_q == adc_ctl_pkg::ST_IDLE)
    else $error("conversion started without a write of one");

  AST_T2_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_power_on_q && state_q == adc_ctl_pkg::ST_IDLE && src_t2 && timer2_ovf |=> busy_q)
    else $error("timer 2 overflow did not start");

  AST_PIN_EDGE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_power_on_q && state_q == adc_ctl_pkg::ST_IDLE && src_pin && pin_rise
    |=> state_q == adc_ctl_pkg::ST_CONV ##0 core_ctl_q.start)
    else $error("start pin edge did not start a conversion");

  AST_WIN_FLAG: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done_evt && window_match |=> window_hit_flag_q)
    else $error("window flag not set on match");

  AST_LEFT_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done_evt && result_align_left_q |=> res_lo_q[5:0] == 6'h00 && res_hi_q == $past(core_result[9:2]))
    else $error("left justified result misplaced");

endmodule : sar_adc_control_sequencer

`default_nettype wire

// File: test/sar_core_model.sv
// behavioural converter core: answers each start pulse with one result
// assumes start pulses from the sequencer, all in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module sar_core_model (
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire adc_ctl_pkg::core_ctl_t core_ctl,
  input  wire logic [3:0]             lat,
  input  wire logic [9:0]             res_in,
  input  wire logic                   match_in,
  output logic                        core_done,
  output logic [9:0]                  core_result,
  output logic                        window_match
);
  logic [4:0] cnt_q;
  // data lines toggle outside the done cycle so a stale value never passes
  always_ff @(posedge clk_sys) begin
    core_done <= 1'b0;
    core_result <= ~core_result;
    window_match <= ~window_match;
    if (sys_rst || !core_ctl.power) begin
      cnt_q <= 5'h00;
      core_result <= 10'h2AA;
      window_match <= 1'b0;
    end else if (core_ctl.start) begin
      cnt_q <= {1'b0, lat} + 5'h01;
    end else if (cnt_q == 5'h01) begin
      cnt_q <= 5'h00;
      core_done <= 1'b1;
      core_result <= res_in;
      window_match <= match_in;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule : sar_core_model
`default_nettype wire

// File: test/tb_sar_adc_control_sequencer.sv
// self-checking bench for the converter control sequencer
// assumes the core model answers starts; timers and start pin come from here
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_control_sequencer;
  logic clk_sys = 0, sys_rst = 1, sfr_wr = 0, sar_tick = 0, timer2_ovf = 0, timer3_ovf = 0;
  logic ext_start_pin = 0, irq_enable = 0, match_in = 0, core_done, window_match, conv_irq;
  logic [7:0] sfr_addr = 8'hE8, sfr_wdata = 8'h00, sfr_rdata, result_high_byte, result_low_byte;
  logic [7:0] cfg, eh, el;
  logic [9:0] res_in = 10'h000, core_result, rv;
  logic [3:0] lat = 4'h0;
  logic [1:0] src;
  logic       ts, al;
  adc_ctl_pkg::core_ctl_t core_ctl;
  int fail_count = 0, comparisons = 0, seed = 32'h128581C3, cyc = 0, n, k;
  int exp_q[$];

  sar_adc_control_sequencer dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sar_tick(sar_tick),
    .timer2_ovf(timer2_ovf), .timer3_ovf(timer3_ovf), .ext_start_pin(ext_start_pin),
    .core_done(core_done), .core_result(core_result), .window_match(window_match),
    .irq_enable(irq_enable), .core_ctl(core_ctl), .result_high_byte(result_high_byte),
    .result_low_byte(result_low_byte), .conv_irq(conv_irq));
  sar_core_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .core_ctl(core_ctl), .lat(lat),
    .res_in(res_in), .match_in(match_in), .core_done(core_done), .core_result(core_result),
    .window_match(window_match));

  always #2.5 clk_sys = ~clk_sys;
  // one converter clock period every four system clocks
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sar_tick <= #1 (cyc % 4 == 3);
  end

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(posedge clk_sys);
    #1;
    sfr_wr = 0;
  endtask : wr

  task clks(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : clks

  task trigger(input logic [1:0] s);
    @(posedge clk_sys);
    #1;
    timer3_ovf = (s == 2'b01);
    ext_start_pin = (s == 2'b10);
    timer2_ovf = (s == 2'b11);
    sfr_wr = (s == 2'b00);
    sfr_wdata = cfg | 8'h10;
    @(posedge clk_sys);
    #1;
    timer3_ovf = 0;
    timer2_ovf = 0;
    sfr_wr = 0;
  endtask : trigger

  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    sys_rst = 0;
    clks(1);
    chk("reset view", 8'h00, sfr_rdata);
    for (int i = 0; i < 16; i++) begin
      src = i[1:0];
      ts = i[2];
      al = 1'($random(seed));
      irq_enable = 1'($random(seed));
      match_in = 1'($random(seed));
      lat = 4'($random(seed));
      res_in = 10'($random(seed));
      cfg = {1'b1, ts, 2'b00, src, 1'b0, al};
      wr(8'hE8, cfg);
      clks(3);
      chk("config view", cfg, sfr_rdata);
      chk("idle track", {7'h00, !ts || src == 2'b10}, {7'h00, core_ctl.track});
      if (src != 2'b00) begin
        wr(8'hE8, cfg | 8'h10);
        clks(3);
        chk("busy refused", cfg, sfr_rdata);
      end
      exp_q.push_back(int'(res_in));
      trigger(src);
      n = 0;
      // a direct start pulse already stands when the trigger returns
      for (k = 0; k < 60; k++) begin
        if (core_ctl.start === 1'b1) break;
        @(posedge clk_sys);
        n += int'(sar_tick);
        #2;
      end
      if (k == 60) begin
        fail_count++;
        complete_run();
      end
      chk("track ticks", 8'h01, {7'h00, (ts && src != 2'b10) ? n == 3 : n < 2});
      // the register view trails the busy state by one cycle
      clks(1);
      chk("busy on", 8'h01, {7'h00, sfr_rdata[4]});
      chk("track off", 8'h00, {7'h00, core_ctl.track});
      for (k = 0; k < 60; k++) begin
        @(posedge clk_sys);
        if (core_done === 1'b1) break;
      end
      if (k == 60) begin
        fail_count++;
        complete_run();
      end
      #2;
      rv = 10'(exp_q.pop_front());
      eh = al ? rv[9:2] : {6'h00, rv[9:8]};
      el = al ? {rv[1:0], 6'h00} : rv[7:0];
      chk("irq", {7'h00, irq_enable}, {7'h00, conv_irq});
      chk("high byte", eh, result_high_byte);
      chk("low byte", el, result_low_byte);
      clks(4);
      chk("done view", cfg | {2'b00, 1'b1, 3'b000, match_in, 1'b0}, sfr_rdata);
      ext_start_pin = 0;
    end
    wr(8'hE8, 8'h10);
    clks(3);
    chk("power off", 8'h00, sfr_rdata);
    chk("core off", 8'h00, {5'h00, core_ctl});
    wr(8'hE9, 8'h90);
    clks(3);
    chk("unmapped", 8'h00, {sfr_rdata[7:1], core_ctl.power});
    complete_run();
  end
endmodule : tb_sar_adc_control_sequencer
`default_nettype wire
